// File: pcoc_pkg.sv
// constants for the clock output and pll control block
// assumes a 100 MHz system clock and an 8-bit register port
// Notes on behaviour
// - select code 0h frees the clock output pin for general I/O use.
// - select code 1h puts the analog PLL output on the pin.
// - select code 2h holds the pin low, 3h holds it high.
// - codes 4h to 7h show the crystal divided by 1, 2, 4 or 8.
// - codes 8h to Bh toggle the pin on timer 0..3 overflow; Ch to Fh reserved.
// - control bit 3 enables the clock on the pin; clear means no clock.
// - feedback code 00 and 11 multiply by 23, 01 by 27, 10 by 28.
// - PLL multiplies crystal by feedback value, halves, then divides by output divider.
// - output divider divides by 8 to 255; values 0 to 7 are reserved.
// - larger trim value gives a lower slow oscillator frequency.
package pcoc_pkg;
    // register offsets
    localparam logic [7:0] ADDR_TRIM   = 8'h3c;
    localparam logic [7:0] ADDR_CTRL   = 8'h3d;
    localparam logic [7:0] ADDR_DIV    = 8'h3e;
    localparam logic [7:0] ADDR_STATUS = 8'h50;
    // control field positions
    localparam int SEL_MSB = 7;
    localparam int SEL_LSB = 4;
    localparam int EN_BIT  = 3;
    localparam int PD_BIT  = 2;
    localparam int FB_MSB  = 1;
    localparam int FB_LSB  = 0;
    // status field positions
    localparam int ST_READY_BIT    = 0;
    localparam int ST_PIN_BIT      = 1;
    localparam int ST_GPIO_BIT     = 2;
    localparam int ST_REJECT_BIT   = 3;
    localparam int ST_RESERVED_BIT = 4;
    // reset values
    localparam logic [7:0] RST_TRIM = 8'h80;
    localparam logic [7:0] RST_CTRL = 8'h04;
    localparam logic [7:0] RST_DIV  = 8'h08;
    // smallest legal output divider
    localparam logic [7:0] DIV_MIN = 8'h08;
    // feedback multipliers
    localparam logic [4:0] MULT_23 = 5'h17;
    localparam logic [4:0] MULT_27 = 5'h1b;
    localparam logic [4:0] MULT_28 = 5'h1c;
    localparam logic [1:0] FB_27   = 2'h1;
    localparam logic [1:0] FB_28   = 2'h2;
    // pin source codes
    localparam logic [3:0] SEL_GPIO  = 4'h0;
    localparam logic [3:0] SEL_PLL   = 4'h1;
    localparam logic [3:0] SEL_LOW   = 4'h2;
    localparam logic [3:0] SEL_HIGH  = 4'h3;
    localparam logic [3:0] SEL_XTAL1 = 4'h4;
    localparam logic [3:0] SEL_XTAL2 = 4'h5;
    localparam logic [3:0] SEL_XTAL4 = 4'h6;
    localparam logic [3:0] SEL_XTAL8 = 4'h7;
    localparam logic [3:0] SEL_TMR0  = 4'h8;
    localparam logic [3:0] SEL_TMR3  = 4'hb;
    // timing
    localparam int CLK_PERIOD_NS   = 10;
    localparam int SETTLE_TIME_NS  = 100000;
    localparam int SETTLE_CYCLES   = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : pcoc_pkg

// File: pcoc_pin_if.sv
// signals between the register side and the pin waveform generator
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface pcoc_pin_if;
    logic [3:0] source_select;
    logic       clock_enable;
    logic       xtal_level;
    logic       pll_level;
    logic       pll_ready;
    logic [3:0] timer_overflow;
    logic       pin_level;
    logic       pin_drive;
    modport ctrl (output source_select, clock_enable, xtal_level, pll_level, pll_ready, timer_overflow,
                  input pin_level, pin_drive);
    modport gen  (input source_select, clock_enable, xtal_level, pll_level, pll_ready, timer_overflow,
                  output pin_level, pin_drive);
endinterface : pcoc_pin_if
`default_nettype wire

// File: pcoc_pin_gen.sv
// waveform generator for the clock output pin
// assumes filtered crystal and pll levels and one-cycle timer overflow pulses
`timescale 1ns/1ps
`default_nettype none
module pcoc_pin_gen (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // control and sources
    pcoc_pin_if.gen   pin
);
    typedef struct packed {
        logic       xtal_prev;
        logic [2:0] div_cnt;
        logic       toggle;
        logic       level;
        logic       drive;
    } pcoc_gen_s;

    pcoc_gen_s q;
    pcoc_gen_s next_q;
    logic [1:0] timer_idx;

    always_comb begin
        next_q = q;
        timer_idx = pin.source_select[1:0];
        next_q.xtal_prev = pin.xtal_level;
        // divide chain advances on each crystal rising edge
        if (pin.xtal_level && !q.xtal_prev) begin
            next_q.div_cnt = q.div_cnt + 3'h1;
        end
        // the toggle only runs while the clock is enabled, so it resumes where it stopped
        if (pin.clock_enable && pin.source_select >= pcoc_pkg::SEL_TMR0 &&
            pin.source_select <= pcoc_pkg::SEL_TMR3 && pin.timer_overflow[timer_idx]) begin
            next_q.toggle = ~q.toggle;
        end
        next_q.drive = (pin.source_select != pcoc_pkg::SEL_GPIO);
        next_q.level = 1'b0;
        case (pin.source_select)
            pcoc_pkg::SEL_GPIO:  next_q.level = 1'b0;
            // no clock until the loop has settled after power up
            pcoc_pkg::SEL_PLL:   next_q.level = pin.clock_enable & pin.pll_ready & pin.pll_level;
            pcoc_pkg::SEL_LOW:   next_q.level = 1'b0;
            pcoc_pkg::SEL_HIGH:  next_q.level = 1'b1;
            pcoc_pkg::SEL_XTAL1: next_q.level = pin.clock_enable & pin.xtal_level;
            pcoc_pkg::SEL_XTAL2: next_q.level = pin.clock_enable & q.div_cnt[0];
            pcoc_pkg::SEL_XTAL4: next_q.level = pin.clock_enable & q.div_cnt[1];
            pcoc_pkg::SEL_XTAL8: next_q.level = pin.clock_enable & q.div_cnt[2];
            default: begin
                // reserved codes drive low
                if (pin.source_select <= pcoc_pkg::SEL_TMR3) begin
                    next_q.level = pin.clock_enable & q.toggle;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign pin.pin_level = q.level;
    assign pin.pin_drive = q.drive;
endmodule : pcoc_pin_gen
`default_nettype wire

// File: pcoc_top.sv
// clock configuration block: slow oscillator trim, pll control and clock output pin
// assumes crystal and pll clocks arrive as pins sampled by clk_i, timers on clk_i
`timescale 1ns/1ps
`default_nettype none
module pcoc_top #(
    parameter int SETTLE_CYCLES = pcoc_pkg::SETTLE_CYCLES
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // register port
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       we_i,
    input  wire logic       re_i,
    output logic      [7:0] rdata_o,
    // clock sources
    input  wire logic       xtal_clk_i,
    input  wire logic       pll_clk_i,
    input  wire logic [3:0] timer_overflow_i,
    // general I/O use of the pin
    input  wire logic       gpio_out_i,
    input  wire logic       gpio_drive_i,
    output logic            gpio_in_o,
    // clock output pin
    input  wire logic       clock_output_pin_i,
    output logic            clock_output_pin_o,
    output logic            clock_output_pin_oe_n_o,
    // analog controls
    output logic            loop_power_down_o,
    output logic      [4:0] pll_multiplier_o,
    output logic      [7:0] output_divider_value_o,
    output logic      [7:0] slow_osc_trim_value_o,
    output logic            pll_ready_o
);
    localparam int CW = $clog2(SETTLE_CYCLES + 1);
    localparam logic [CW-1:0] SETTLE_LAST = CW'(SETTLE_CYCLES - 1);

    typedef struct packed {
        logic [2:0]    xtal_sync;
        logic [2:0]    pll_sync;
        logic [2:0]    pin_sync;
        logic          xtal_level;
        logic          pll_level;
        logic          pin_level_in;
        logic [7:0]    trim;
        logic [7:0]    ctrl;
        logic [7:0]    div;
        logic [CW-1:0] settle;
        logic          ready;
        logic [7:0]    rdata;
        logic          div_reject;
        logic          sel_reserved;
        logic          pin;
        logic          oe_n;
        logic          gpio_in;
        logic          pd;
        logic [4:0]    mult;
    } pcoc_top_s;

    pcoc_top_s q;
    pcoc_top_s next_q;

    pcoc_pin_if pin_bus ();

    // a level change counts only once the second and third stages agree
    function automatic logic pcoc_filter(input logic [2:0] chain, input logic old_level);
        pcoc_filter = (chain[1] == chain[2]) ? chain[2] : old_level;
    endfunction : pcoc_filter

    function automatic logic [4:0] pcoc_mult(input logic [1:0] code);
        if (code == pcoc_pkg::FB_27) begin
            pcoc_mult = pcoc_pkg::MULT_27;
        end else if (code == pcoc_pkg::FB_28) begin
            pcoc_mult = pcoc_pkg::MULT_28;
        end else begin
            pcoc_mult = pcoc_pkg::MULT_23;
        end
    endfunction : pcoc_mult

    function automatic logic [7:0] pcoc_status(input pcoc_top_s s);
        pcoc_status = 8'h00;
        pcoc_status[pcoc_pkg::ST_READY_BIT]    = s.ready;
        pcoc_status[pcoc_pkg::ST_PIN_BIT]      = s.pin;
        pcoc_status[pcoc_pkg::ST_GPIO_BIT]     = s.gpio_in;
        pcoc_status[pcoc_pkg::ST_REJECT_BIT]   = s.div_reject;
        pcoc_status[pcoc_pkg::ST_RESERVED_BIT] = s.sel_reserved;
    endfunction : pcoc_status

    always_comb begin
        next_q = q;
        // pin synchronisers: only stage two and three feed the filter
        next_q.xtal_sync = {q.xtal_sync[1:0], xtal_clk_i};
        next_q.pll_sync  = {q.pll_sync[1:0], pll_clk_i};
        next_q.pin_sync  = {q.pin_sync[1:0], clock_output_pin_i};
        next_q.xtal_level   = pcoc_filter(q.xtal_sync, q.xtal_level);
        next_q.pll_level    = pcoc_filter(q.pll_sync, q.pll_level);
        next_q.pin_level_in = pcoc_filter(q.pin_sync, q.pin_level_in);

        // status read clears the sticky flags; a new event in the same cycle wins
        if (re_i && addr_i == pcoc_pkg::ADDR_STATUS) begin
            next_q.div_reject   = 1'b0;
            next_q.sel_reserved = 1'b0;
        end

        // register writes
        if (we_i) begin
            if (addr_i == pcoc_pkg::ADDR_TRIM) begin
                next_q.trim = wdata_i;
            end else if (addr_i == pcoc_pkg::ADDR_CTRL) begin
                next_q.ctrl = wdata_i;
                if (wdata_i[pcoc_pkg::SEL_MSB:pcoc_pkg::SEL_LSB] > pcoc_pkg::SEL_TMR3) begin
                    next_q.sel_reserved = 1'b1;
                end
            end else if (addr_i == pcoc_pkg::ADDR_DIV) begin
                // a reserved divider would break the loop, so the old value is kept
                if (wdata_i >= pcoc_pkg::DIV_MIN) begin
                    next_q.div = wdata_i;
                end else begin
                    next_q.div_reject = 1'b1;
                end
            end
        end

        // read data stands one cycle after the strobe, zero otherwise
        next_q.rdata = 8'h00;
        if (re_i) begin
            if (addr_i == pcoc_pkg::ADDR_TRIM) begin
                next_q.rdata = q.trim;
            end else if (addr_i == pcoc_pkg::ADDR_CTRL) begin
                next_q.rdata = q.ctrl;
            end else if (addr_i == pcoc_pkg::ADDR_DIV) begin
                next_q.rdata = q.div;
            end else if (addr_i == pcoc_pkg::ADDR_STATUS) begin
                next_q.rdata = pcoc_status(q);
            end else begin
                next_q.rdata = 8'h00;
            end
        end

        // settle timer restarts on every power down
        next_q.pd = q.ctrl[pcoc_pkg::PD_BIT];
        if (q.ctrl[pcoc_pkg::PD_BIT]) begin
            next_q.settle = '0;
            next_q.ready  = 1'b0;
        end else if (q.settle == SETTLE_LAST) begin
            next_q.ready = 1'b1;
        end else begin
            next_q.settle = q.settle + CW'(1);
        end

        // stage one multiplies and halves, stage two divides by the output divider
        next_q.mult = pcoc_mult(q.ctrl[pcoc_pkg::FB_MSB:pcoc_pkg::FB_LSB]);

        // in I/O mode the pin belongs to the general I/O logic
        if (pin_bus.pin_drive) begin
            next_q.pin  = pin_bus.pin_level;
            next_q.oe_n = 1'b0;
        end else begin
            next_q.pin  = gpio_out_i;
            next_q.oe_n = ~gpio_drive_i;
        end
        next_q.gpio_in = q.pin_level_in;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q      <= '0;
            q.trim <= pcoc_pkg::RST_TRIM;
            q.ctrl <= pcoc_pkg::RST_CTRL;
            q.div  <= pcoc_pkg::RST_DIV;
            q.oe_n <= 1'b1;
            q.pd   <= 1'b1;
            q.mult <= pcoc_pkg::MULT_23;
        end else begin
            q <= next_q;
        end
    end

    assign pin_bus.source_select  = q.ctrl[pcoc_pkg::SEL_MSB:pcoc_pkg::SEL_LSB];
    assign pin_bus.clock_enable   = q.ctrl[pcoc_pkg::EN_BIT];
    assign pin_bus.xtal_level     = q.xtal_level;
    assign pin_bus.pll_level      = q.pll_level;
    assign pin_bus.pll_ready      = q.ready;
    assign pin_bus.timer_overflow = timer_overflow_i;

    pcoc_pin_gen u_gen (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .pin   (pin_bus.gen)
    );

    assign rdata_o                 = q.rdata;
    assign gpio_in_o               = q.gpio_in;
    assign clock_output_pin_o      = q.pin;
    assign clock_output_pin_oe_n_o = q.oe_n;
    assign loop_power_down_o       = q.pd;
    assign pll_multiplier_o        = q.mult;
    assign output_divider_value_o  = q.div;
    // analog trim: a higher code slows the oscillator
    assign slow_osc_trim_value_o   = q.trim;
    assign pll_ready_o             = q.ready;
endmodule : pcoc_top
`default_nettype wire

// File: pcoc_top_sva.sv
// port assertions for the clock output and pll control block
// assumes binding onto pcoc_top with a short settle count of 8
`timescale 1ns/1ps
`default_nettype none
module pcoc_top_sva #(
    parameter int SETTLE_CYCLES = 8
) (
    // clock and reset
    input wire logic       clk_i,
    input wire logic       rst_i,
    // register port and io side
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       we_i,
    input wire logic       gpio_out_i,
    input wire logic       gpio_drive_i,
    // observed outputs
    input wire logic       clock_output_pin_o,
    input wire logic       clock_output_pin_oe_n_o,
    input wire logic       loop_power_down_o,
    input wire logic [4:0] pll_multiplier_o,
    input wire logic [7:0] output_divider_value_o,
    input wire logic       pll_ready_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic ctl_wr;
    logic div_wr;
    assign ctl_wr = we_i && addr_i == 8'h3d;
    assign div_wr = we_i && addr_i == 8'h3e;
    // powered-up run length, so ready can be held to the exact settle count
    logic [15:0] low_run;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            low_run <= 16'h0000;
        end else if (loop_power_down_o) begin
            low_run <= 16'h0000;
        end else if (low_run != 16'hffff) begin
            low_run <= low_run + 16'h0001;
        end
    end

    a_pd_follow: assert property (ctl_wr |-> ##2 loop_power_down_o == $past(wdata_i[2], 2))
        else $error("power down lags control");
    a_mult_code: assert property (ctl_wr ##2 1'b1 |-> pll_multiplier_o == ($past(wdata_i[1:0], 2) == 2'h1 ? 5'h1b :
        $past(wdata_i[1:0], 2) == 2'h2 ? 5'h1c : 5'h17)) else $error("wrong multiplier");
    a_div_load: assert property ((div_wr && wdata_i >= 8'h08) ##1 !div_wr |=>
        output_divider_value_o == $past(wdata_i, 2)) else $error("divider not loaded");
    a_const_low: assert property (ctl_wr && wdata_i[7:4] == 4'h2 ##1 !ctl_wr [*3] |->
        !clock_output_pin_o && !clock_output_pin_oe_n_o) else $error("pin not held low");
    a_const_high: assert property (ctl_wr && wdata_i[7:4] == 4'h3 ##1 !ctl_wr [*3] |->
        clock_output_pin_o && !clock_output_pin_oe_n_o) else $error("pin not held high");
    a_io_follow: assert property (ctl_wr && wdata_i[7:4] == 4'h0 ##1 (!ctl_wr && $stable(gpio_out_i)
        && $stable(gpio_drive_i)) [*3] |-> clock_output_pin_o == gpio_out_i
        && clock_output_pin_oe_n_o == !gpio_drive_i) else $error("io mode not followed");
    a_enable_off: assert property (ctl_wr && !wdata_i[3] && wdata_i[7:4] inside {4'h1, [4'h4:4'hb]}
        ##1 !ctl_wr [*3] |-> !clock_output_pin_o) else $error("clock shown while disabled");
    a_ready_wait: assert property ($rose(pll_ready_o) |-> low_run == 16'(SETTLE_CYCLES - 1))
        else $error("ready before settle");
    a_ready_off: assert property (loop_power_down_o |=> !pll_ready_o)
        else $error("ready while powered down");
endmodule : pcoc_top_sva

bind pcoc_top pcoc_top_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
    .gpio_out_i(gpio_out_i), .gpio_drive_i(gpio_drive_i), .clock_output_pin_o(clock_output_pin_o),
    .clock_output_pin_oe_n_o(clock_output_pin_oe_n_o), .loop_power_down_o(loop_power_down_o),
    .pll_multiplier_o(pll_multiplier_o), .output_divider_value_o(output_divider_value_o),
    .pll_ready_o(pll_ready_o)
);
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the clock output and pll control block
// assumes a 100 MHz clock and a settle count shortened to 8 cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} pcoc_row_s;
    logic       clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, re_i = 1'b0, xtal_clk_i = 1'b0, pll_clk_i = 1'b0;
    logic       gpio_out_i = 1'b0, gpio_drive_i = 1'b0, pin_level;
    logic       gpio_in_o, clock_output_pin_o, clock_output_pin_oe_n_o, loop_power_down_o, pll_ready_o;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, output_divider_value_o, slow_osc_trim_value_o;
    logic [3:0] timer_overflow_i = 4'h0;
    logic [4:0] pll_multiplier_o;
    logic [4:0] mult[4] = '{5'h17, 5'h1b, 5'h1c, 5'h17};
    logic [2:0] slow_cnt = 3'h0;
    wire logic  clock_output_pin_i;
    int         bad_count = 0, tests_run = 0, edges;
    pcoc_row_s  rows[7];

    // pull-up on the pin while nobody drives it
    assign clock_output_pin_i = clock_output_pin_oe_n_o ? 1'b1 : clock_output_pin_o;

    pcoc_top #(.SETTLE_CYCLES(8)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
        .rdata_o(rdata_o), .xtal_clk_i(xtal_clk_i), .pll_clk_i(pll_clk_i), .timer_overflow_i(timer_overflow_i),
        .gpio_out_i(gpio_out_i), .gpio_drive_i(gpio_drive_i), .gpio_in_o(gpio_in_o),
        .clock_output_pin_i(clock_output_pin_i), .clock_output_pin_o(clock_output_pin_o),
        .clock_output_pin_oe_n_o(clock_output_pin_oe_n_o), .loop_power_down_o(loop_power_down_o),
        .pll_multiplier_o(pll_multiplier_o), .output_divider_value_o(output_divider_value_o),
        .slow_osc_trim_value_o(slow_osc_trim_value_o), .pll_ready_o(pll_ready_o)
    );

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // slow stand-ins: sampled clocks must stay well below the system rate
    always @(posedge clk_i) begin
        slow_cnt <= slow_cnt + 3'h1;
        if (slow_cnt == 3'h7) begin
            xtal_clk_i <= ~xtal_clk_i;
        end
        if (slow_cnt[1:0] == 2'h3) begin
            pll_clk_i <= ~pll_clk_i;
        end
    end

    task automatic chk(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : wait_n

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        we_i <= 1'b1;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        re_i <= 1'b1;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1;
        chk(rdata_o === e, "read data");
    endtask : rd

    task automatic pulse(input int t);
        @(posedge clk_i);
        timer_overflow_i <= 4'h1 << t;
        @(posedge clk_i);
        timer_overflow_i <= 4'h0;
        wait_n(4);
    endtask : pulse

    // counts rising pin edges over 256 cycles, one edge of slack for phase
    task automatic count(input logic [7:0] ctrl, input int exp);
        wr(8'h3d, ctrl);
        wait_n(8);
        edges = 0;
        repeat (256) begin
            pin_level = clock_output_pin_o;
            wait_n(1);
            if (clock_output_pin_o === 1'b1 && pin_level === 1'b0) edges++;
        end
        chk(edges >= exp - 1 && edges <= exp + 1, "pin edge count");
    endtask : count

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (10000) @(posedge clk_i);
        bad_count++;
        print_verdict();
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rows = '{'{8'h3c, 8'h00, 8'h00}, '{8'h3c, 8'hff, 8'hff}, '{8'h3e, 8'hff, 8'hff},
                 '{8'h3e, 8'h07, 8'hff}, '{8'h3e, 8'h08, 8'h08}, '{8'h3d, 8'h26, 8'h26}, '{8'h40, 8'h55, 8'h00}};
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        chk(output_divider_value_o === 8'h08 && slow_osc_trim_value_o === 8'hff, "analog values");
        for (int i = 0; i < 4; i++) begin
            wr(8'h3d, {6'h01, i[1:0]});
            wait_n(2);
            chk(pll_multiplier_o === mult[i], "multiplier");
        end
        gpio_out_i <= 1'b1;
        gpio_drive_i <= 1'b1;
        wr(8'h3d, 8'h08);
        wait_n(4);
        chk(clock_output_pin_o === 1'b1 && clock_output_pin_oe_n_o === 1'b0, "io drive");
        gpio_out_i <= 1'b0;
        wait_n(8);
        chk(clock_output_pin_o === 1'b0 && gpio_in_o === 1'b0, "io loop back");
        gpio_drive_i <= 1'b0;
        wait_n(8);
        chk(clock_output_pin_oe_n_o === 1'b1 && gpio_in_o === 1'b1, "io release");
        wr(8'h3d, 8'h20);
        wait_n(4);
        chk(clock_output_pin_o === 1'b0 && clock_output_pin_oe_n_o === 1'b0, "hold low");
        wr(8'h3d, 8'h30);
        wait_n(4);
        chk(clock_output_pin_o === 1'b1 && clock_output_pin_oe_n_o === 1'b0, "hold high");
        wr(8'h3d, 8'hc8);
        wait_n(4);
        chk(clock_output_pin_o === 1'b0, "reserved select");
        wait_n(4);
        // sticky flags from the reserved select and the refused divider, then cleared by the read
        rd(8'h50, 8'h19);
        rd(8'h50, 8'h01);
        for (int t = 0; t < 4; t++) begin
            wr(8'h3d, {4'h8 + t[3:0], 4'h8});
            wait_n(4);
            pin_level = clock_output_pin_o;
            pulse((t + 1) % 4);
            chk(clock_output_pin_o === pin_level, "foreign timer");
            pulse(t);
            chk(clock_output_pin_o === ~pin_level, "own timer");
        end
        for (int m = 4; m < 8; m++) count({m[3:0], 4'h8}, 16 >> (m - 4));
        count(8'h50, 0);
        count(8'h1c, 0);
        wr(8'h3d, 8'h18);
        wait_n(3);
        chk(pll_ready_o === 1'b0, "ready too early");
        for (int n = 0; n < 40 && pll_ready_o !== 1'b1; n++) wait_n(1);
        chk(pll_ready_o === 1'b1, "pll ready");
        count(8'h18, 32);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h3c, 8'h80);
        rd(8'h3d, 8'h04);
        rd(8'h3e, 8'h08);
        chk(loop_power_down_o === 1'b1 && pll_multiplier_o === 5'h17, "reset outputs");
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
